// file: bench/edlk_ser_model.sv
`timescale 1ns/100ps
// Far-end serializer: start clock bit, ten data bits MSB first, stop clock bit, back to back
module edlk_ser_model
  import edlk_pkg::*;
#(
  parameter logic [DATA_BITS-1:0] TRAIN_WORD = 10'h3E0  // One rising edge a frame, so one alignment only
) (
  input  wire logic                 clk_link_i,
  input  wire logic                 training_request_a_i,
  input  wire logic                 training_request_b_i,
  input  wire logic                 live_i,               // High sends a changing count
  input  wire logic                 bad_i,                // High inverts both clock bits
  input  wire logic [DATA_BITS-1:0] data_i,
  output logic                      serial_o,
  output logic                      frame_o               // High while a start bit is out
);
  logic [DATA_BITS:0]   rest_r = '0;     // Data bits and stop bit still to send
  logic [3:0]           pos_r  = 4'h0;   // Bit position in frame
  logic [DATA_BITS-1:0] cnt_r  = 10'h000; // Live traffic, never repeats within a lock search
  initial serial_o = 1'b0;
  initial frame_o = 1'b0;
  // Word and clock bits are fixed at each frame start, so inputs may change any time in between
  always @(posedge clk_link_i) begin
    frame_o <= (pos_r == 4'h0);
    if (pos_r == 4'h0) begin
      serial_o <= ~bad_i;
      if (training_request_a_i || training_request_b_i) begin
        rest_r <= {TRAIN_WORD, bad_i};
      end else begin
        rest_r <= {(live_i ? cnt_r : data_i), bad_i};
      end
      cnt_r <= cnt_r + 10'h0A5;
    end else begin
      serial_o <= rest_r[DATA_BITS];
      rest_r   <= rest_r << 1;
    end
    pos_r <= (pos_r == BIT_LAST) ? 4'h0 : pos_r + 4'h1;
  end
endmodule

// file: bench/embedded_clock_deser_lock_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the lock and output control of the word receiver
module embedded_clock_deser_lock_bench;
  import edlk_pkg::*;
  logic                 clk_sys_i, clk_link_i, rst_b_i;
  logic                 power_down_n_i, output_enable_i, strobe_rise_i, rx_ready_i;
  logic [DATA_BITS-1:0] word_o;
  logic                 word_valid_o, word_oe_n_o, rec_clk_o, rec_clk_oe_n_o;
  logic                 unlocked_o, unlocked_oe_n_o, buf_ready_o;
  logic                 serial_w, frame_w;
  logic                 fb_en, live, bad, saw_unlk, train_b;
  logic [DATA_BITS-1:0] data;
  int                   mismatches, checks;

  edlk_rx u_edlk_rx (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_link_i(clk_link_i), .serial_i(serial_w),
    .power_down_n_i(power_down_n_i), .output_enable_i(output_enable_i), .strobe_rise_i(strobe_rise_i),
    .rx_ready_i(rx_ready_i), .word_o(word_o), .word_valid_o(word_valid_o), .word_oe_n_o(word_oe_n_o),
    .rec_clk_o(rec_clk_o), .rec_clk_oe_n_o(rec_clk_oe_n_o), .unlocked_o(unlocked_o),
    .unlocked_oe_n_o(unlocked_oe_n_o), .buf_ready_o(buf_ready_o));

  // Unlocked flag fed back to one training request while feedback is on
  edlk_ser_model u_edlk_ser_model (.clk_link_i(clk_link_i), .training_request_a_i(unlocked_o & fb_en),
    .training_request_b_i(train_b), .live_i(live), .bad_i(bad), .data_i(data), .serial_o(serial_w),
    .frame_o(frame_w));

  // System clock, 8 ns
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Reference clock runs free, 6 ns, offset so no edge lines up with the system clock
  initial begin
    clk_link_i = 1'b0;
    #1.3;
    forever #3 clk_link_i = ~clk_link_i;
  end
  // Sticky record of any unlocked indication
  always @(posedge clk_sys_i) if (unlocked_o !== 1'b0) saw_unlk <= 1'b1;

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // Inputs set after this task move one nanosecond after the system edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Waits for n frame starts; each wait is bounded by thirty link clocks, two and a half frames
  task automatic frames(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk_link_i);
        #1;
        k++;
      end while (frame_w !== 1'b1 && k < 30);
      chk(frame_w === 1'b1, "frame start missing");
      if (frame_w !== 1'b1) results();
    end
  endtask

  task automatic wait_lock(input logic want, input int lim);
    int n;
    n = 0;
    while (unlocked_o !== want && n < lim) begin
      cyc(1);
      n++;
    end
    chk(unlocked_o === want, "lock state not reached in time");
    if (n >= lim) results();
  endtask

  // Waits for a presented word; a strobe edge must come with it
  task automatic get_word(output logic [DATA_BITS-1:0] w, input int lim);
    int n;
    n = 0;
    while (word_valid_o !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    chk(word_valid_o === 1'b1, "no word presented");
    chk(rec_clk_o === strobe_rise_i, "strobe level wrong with new word");
    if (n >= lim) results();
    w = word_o;
    cyc(1);
  endtask

  task automatic t_start;
    cyc(5);
    chk(unlocked_o === 1'b1, "not unlocked at start-up");
    chk(word_oe_n_o === 1'b1 && rec_clk_oe_n_o === 1'b1, "driven before lock");
    chk(unlocked_oe_n_o === 1'b0, "flag not driven");
    wait_lock(1'b0, 2000);
    cyc(4);
    chk(word_oe_n_o === 1'b0 && rec_clk_oe_n_o === 1'b0, "not driven after lock");
    $display("test start done");
  endtask

  task automatic t_data;
    logic [DATA_BITS-1:0] w;
    int n;
    data = 10'h2B4;
    n = 0;
    w = '0;
    while (w !== 10'h2B4 && n < 6) begin
      get_word(w, 200);
      n++;
    end
    chk(w === 10'h2B4, "word content wrong");
    strobe_rise_i = 1'b0;
    cyc(4);
    get_word(w, 200);
    chk(w === 10'h2B4, "word content wrong, falling strobe");
    strobe_rise_i = 1'b1;
    cyc(4);
    $display("test data done");
  endtask

  task automatic t_glitch;
    fb_en = 1'b0;
    frames(1);
    saw_unlk = 1'b0;
    bad = 1'b1;
    frames(3);
    bad = 1'b0;
    frames(1);
    bad = 1'b1;
    frames(3);
    bad = 1'b0;
    frames(3);
    chk(saw_unlk === 1'b0, "lock lost on three bad frames");
    $display("test glitch done");
  endtask

  task automatic t_loss;
    logic [DATA_BITS-1:0] a, b;
    // Live traffic from the start, so the hunt never sees a repeating word it could align to falsely
    live = 1'b1;
    bad = 1'b1;
    frames(4);
    bad = 1'b0;
    wait_lock(1'b1, 100);
    cyc(4);
    chk(word_oe_n_o === 1'b1 && rec_clk_oe_n_o === 1'b1, "driven while unlocked");
    wait_lock(1'b0, 20000);
    // Words from before the loss are never compared; only fresh words after relock count
    get_word(a, 200);
    get_word(b, 200);
    chk(b === a + 10'h0A5, "random lock on wrong alignment");
    $display("test loss done");
  endtask

  task automatic t_stall;
    logic [DATA_BITS-1:0] w;
    rx_ready_i = 1'b0;
    cyc(60);
    chk(buf_ready_o === 1'b0 && word_valid_o === 1'b1, "buffer not full in stall");
    w = word_o;
    cyc(20);
    chk(word_o === w && word_valid_o === 1'b1, "held word changed in stall");
    rx_ready_i = 1'b1;
    cyc(30);
    chk(buf_ready_o === 1'b1, "buffer not drained");
    $display("test stall done");
  endtask

  task automatic t_oe;
    output_enable_i = 1'b0;
    cyc(5);
    chk(unlocked_oe_n_o === 1'b1 && word_oe_n_o === 1'b1 && rec_clk_oe_n_o === 1'b1, "oe low not released");
    output_enable_i = 1'b1;
    cyc(5);
    chk(unlocked_oe_n_o === 1'b0 && word_oe_n_o === 1'b0, "oe high not driven");
    $display("test enable done");
  endtask

  task automatic t_pdn;
    logic [DATA_BITS-1:0] w;
    live = 1'b0;
    // Relock through the second training request this time, feedback off
    fb_en = 1'b0;
    train_b = 1'b1;
    power_down_n_i = 1'b0;
    cyc(8);
    chk(unlocked_oe_n_o === 1'b1 && word_oe_n_o === 1'b1 && rec_clk_oe_n_o === 1'b1, "power down drives");
    chk(unlocked_o === 1'b1, "lock kept in power down");
    power_down_n_i = 1'b1;
    wait_lock(1'b0, 2000);
    get_word(w, 200);
    chk(w === 10'h3E0, "no training word on second request");
    train_b = 1'b0;
    $display("test power down done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_b_i = 1'b0;
    power_down_n_i = 1'b1;
    output_enable_i = 1'b1;
    strobe_rise_i = 1'b1;
    rx_ready_i = 1'b1;
    fb_en = 1'b1;
    train_b = 1'b0;
    live = 1'b0;
    bad = 1'b0;
    saw_unlk = 1'b0;
    data = 10'h2B4;
    mismatches = 0;
    checks = 0;
    cyc(10);
    rst_b_i = 1'b1;
    t_start();
    t_data();
    t_glitch();
    t_loss();
    t_stall();
    t_oe();
    t_pdn();
    results();
  end
endmodule

// file: hw/edlk_buf.sv
`timescale 1ns/100ps
// Small shift-style buffer; head word always sits in mem[0], a register
module edlk_buf
  import edlk_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_BITS,
  parameter int unsigned DEPTH = BUF_DEPTH
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned CW = $clog2(DEPTH + 1);

  // Whole state of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // Entries, head at index 0
    logic [CW-1:0]               cnt;   // Words held
  } edlk_buf_t;

  edlk_buf_t s_r;    // Registered state
  edlk_buf_t s_nxt;  // Next state
  logic      push;   // Word accepted this cycle
  logic      pop;    // Word taken this cycle

  assign in_ready_o  = (s_r.cnt != CW'(DEPTH));
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o  = s_r.mem[0];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Shift down on pop, write behind the last held word on push
  always_comb begin
    int unsigned wr;
    wr    = 0;
    s_nxt = s_r;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_nxt.mem[i] = s_r.mem[i+1];
      end
    end
    wr = int'(s_r.cnt) - (pop ? 1 : 0);
    if (push) begin
      s_nxt.mem[wr] = in_data_i;
    end
    s_nxt.cnt = CW'(wr + (push ? 1 : 0));
    // Flush drops everything; stale words must not leak past a relock
    if (flush_i) begin
      s_nxt.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  AST_BUF_BOUND: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_r.cnt <= CW'(DEPTH)) else $error("Buffer count beyond depth");

endmodule

// file: hw/edlk_pkg.sv
// Shared constants for the embedded-clock word receiver
package edlk_pkg;

  // Frame layout: one start clock bit, ten data bits, one stop clock bit
  localparam int unsigned DATA_BITS    = 10;
  localparam int unsigned FRAME_BITS   = DATA_BITS + 2;
  localparam int unsigned CNT_W        = 4;                 // Bit position counter width
  localparam logic [3:0]  BIT_LAST     = 4'hB;              // Last bit position of a frame
  localparam logic [3:0]  BIT_FIRST    = 4'h1;              // Position right after an aligned frame
  localparam logic [3:0]  BIT_BOUNDARY = 4'h0;              // Shift register holds a whole frame
  localparam int unsigned POS_START    = FRAME_BITS - 1;    // Start clock bit position
  localparam int unsigned POS_STOP     = 0;                 // Stop clock bit position
  localparam logic        CLK_START    = 1'b1;              // Embedded clock bit, first
  localparam logic        CLK_STOP     = 1'b0;              // Embedded clock bit, last

  // Loss of lock after this many bad clock fields in a row
  localparam logic [2:0]  LOSS_LIMIT   = 3'h4;
  // Good frames needed after a candidate alignment before lock is declared
  localparam logic [2:0]  CONFIRM_LIM  = 3'h4;

  // Buffer depth between link and output stage
  localparam int unsigned BUF_DEPTH    = 2;

  // Reset values
  localparam logic [2:0]  CNT_RST      = 3'h0;
  localparam logic        UNLOCK_RST   = 1'b1;              // Unlocked from start-up
  localparam logic        OE_N_RST     = 1'b1;              // Pins released at reset

  // Alignment state of the link side
  typedef enum logic [1:0] {
    ST_HUNT,
    ST_CONFIRM,
    ST_LOCKED
  } edlk_state_t;

endpackage

// file: hw/edlk_rx.sv
`timescale 1ns/100ps
// Contract
// - Word is ten data bits between clock bits
// - Check clock bits, flag lost lock high
// - Data and strobe released until stream detected and locked; unlocked flag driven throughout
// - Unlocked high from start until lock
// - Random lock to live traffic without training
// - Words valid while unlocked flag low
// - Loss only after four bad clock fields
// - Up to three corrupt words, unmarked
// - Relock by training or random lock
// - Edge select picks active strobe edge
// - Output enable low releases all outputs
// - Power down stops recovery, releases outputs
// - Unlocked releases data and strobe
module edlk_rx
  import edlk_pkg::*;
(
  input  wire logic                 clk_sys_i,        // System clock
  input  wire logic                 rst_b_i,          // Async reset, active low
  input  wire logic                 clk_link_i,       // Local reference clock, one tick per serial bit
  input  wire logic                 serial_i,         // Serial stream, MSB first
  input  wire logic                 power_down_n_i,   // Low stops recovery
  input  wire logic                 output_enable_i,  // Low releases outputs
  input  wire logic                 strobe_rise_i,    // High rising strobe, low falling
  input  wire logic                 rx_ready_i,       // Consumer takes the presented word
  output logic [DATA_BITS-1:0]      word_o,           // Received word
  output logic                      word_valid_o,     // Word presented
  output logic                      word_oe_n_o,      // Low while word_o driven
  output logic                      rec_clk_o,        // Recovered word strobe
  output logic                      rec_clk_oe_n_o,   // Low while rec_clk_o driven
  output logic                      unlocked_o,       // High while not locked
  output logic                      unlocked_oe_n_o,  // Low while unlocked_o driven
  output logic                      buf_ready_o       // Buffer could take a word
);

  // ---------------- Link domain ----------------

  // Link state, clocked by the reference clock
  typedef struct packed {
    logic                  ser_s1;    // Serial sync, first stage
    logic                  ser_s2;    // Serial sync, second stage
    logic                  pdn_s1;    // Power-down sync, first stage
    logic                  pdn_s2;    // Power-down sync, second stage
    logic [FRAME_BITS-1:0] sr;        // Last twelve bits seen
    logic [CNT_W-1:0]      bit_cnt;   // Position within the frame
    edlk_state_t           st;        // Alignment state
    logic [2:0]            good_cnt;  // Good frames while confirming
    logic [2:0]            bad_cnt;   // Bad clock fields in a row
    logic [DATA_BITS-1:0]  word;      // Held word for the other domain
    logic                  word_tgl;  // Flips once per emitted word
    logic                  locked;    // Lock level for the other domain
  } edlk_link_t;

  edlk_link_t l_r;          // Registered link state
  edlk_link_t l_nxt;        // Next link state
  logic [1:0] rst_link_q;   // Link reset synchroniser
  logic       rst_link_b;   // Link reset, released on the link clock
  logic       boundary;     // Shift register holds an aligned frame
  logic       field_ok;     // Both clock bits correct

  // Clock field check, used for hunting and for tracking
  function automatic logic clk_field_ok(input logic [FRAME_BITS-1:0] f);
    clk_field_ok = (f[POS_START] == CLK_START) && (f[POS_STOP] == CLK_STOP);
  endfunction

  // Reset asserts at once and releases on the link clock
  always_ff @(posedge clk_link_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_link_q <= 2'h0;
    end else begin
      rst_link_q <= {rst_link_q[0], 1'b1};
    end
  end
  assign rst_link_b = rst_link_q[1];

  assign boundary = (l_r.bit_cnt == BIT_BOUNDARY);
  assign field_ok = clk_field_ok(l_r.sr);

  // Alignment, lock tracking and word emission
  always_comb begin
    l_nxt        = l_r;
    l_nxt.ser_s1 = serial_i;
    l_nxt.ser_s2 = l_r.ser_s1;
    l_nxt.pdn_s1 = power_down_n_i;
    l_nxt.pdn_s2 = l_r.pdn_s1;
    l_nxt.sr     = {l_r.sr[FRAME_BITS-2:0], l_r.ser_s2};
    l_nxt.bit_cnt = (l_r.bit_cnt == BIT_LAST) ? BIT_BOUNDARY : l_r.bit_cnt + 4'h1;
    case (l_r.st)
      ST_HUNT: begin
        // Any position with a good clock field is a candidate; no training needed
        if (field_ok) begin
          l_nxt.st       = ST_CONFIRM;
          l_nxt.bit_cnt  = BIT_FIRST;
          l_nxt.good_cnt = CNT_RST;
        end
      end
      ST_CONFIRM: begin
        // A few good frames in a row guard against a false alignment on data
        if (boundary) begin
          if (!field_ok) begin
            l_nxt.st = ST_HUNT;
          end else if (l_r.good_cnt == CONFIRM_LIM - 3'h1) begin
            l_nxt.st      = ST_LOCKED;
            l_nxt.locked  = 1'b1;
            l_nxt.bad_cnt = CNT_RST;
          end else begin
            l_nxt.good_cnt = l_r.good_cnt + 3'h1;
          end
        end
      end
      ST_LOCKED: begin
        if (boundary) begin
          if (field_ok) begin
            l_nxt.bad_cnt = CNT_RST;
          end else begin
            l_nxt.bad_cnt = l_r.bad_cnt + 3'h1;
          end
          if (!field_ok && l_r.bad_cnt == LOSS_LIMIT - 3'h1) begin
            // Fourth bad field in a row: lock is gone
            l_nxt.st      = ST_HUNT;
            l_nxt.locked  = 1'b0;
            l_nxt.bad_cnt = CNT_RST;
          end else begin
            // Words with a bad field still go out; no per-word mark exists
            l_nxt.word     = l_r.sr[POS_START-1:POS_STOP+1];
            l_nxt.word_tgl = ~l_r.word_tgl;
          end
        end
      end
      default: begin
        l_nxt.st = ST_HUNT;
      end
    endcase
    // Power down stops recovery outright
    if (!l_r.pdn_s2) begin
      l_nxt.st       = ST_HUNT;
      l_nxt.locked   = 1'b0;
      l_nxt.bad_cnt  = CNT_RST;
      l_nxt.good_cnt = CNT_RST;
    end
  end

  // Link state register
  always_ff @(posedge clk_link_i or negedge rst_link_b) begin
    if (!rst_link_b) begin
      l_r    <= '0;
      l_r.st <= ST_HUNT;
    end else begin
      l_r <= l_nxt;
    end
  end

  AST_LOSS_AFTER_FOUR: assert property (@(posedge clk_link_i) disable iff (!rst_link_b)
    (l_r.st == ST_LOCKED && l_r.pdn_s2 && boundary && !field_ok && l_r.bad_cnt == 3'h3)
      |=> (l_r.st == ST_HUNT && !l_r.locked)) else $error("Lock not dropped on fourth bad field");
  AST_NO_EARLY_LOSS: assert property (@(posedge clk_link_i) disable iff (!rst_link_b)
    (l_r.st == ST_LOCKED && l_r.pdn_s2 && boundary && !field_ok && l_r.bad_cnt < 3'h3)
      |=> (l_r.st == ST_LOCKED && l_r.locked)) else $error("Lock dropped too early");
  AST_BAD_CLEAR: assert property (@(posedge clk_link_i) disable iff (!rst_link_b)
    (l_r.st == ST_LOCKED && boundary && field_ok) |=> (l_r.bad_cnt == 3'h0))
    else $error("Bad count not cleared by a good field");
  AST_RANDOM_HUNT: assert property (@(posedge clk_link_i) disable iff (!rst_link_b)
    (l_r.st == ST_HUNT && l_r.pdn_s2 && field_ok) |=> (l_r.st == ST_CONFIRM && l_r.bit_cnt == BIT_FIRST))
    else $error("Candidate alignment not taken");
  AST_EMIT_WORD: assert property (@(posedge clk_link_i) disable iff (!rst_link_b)
    (l_r.st == ST_LOCKED && l_r.pdn_s2 && boundary && field_ok)
      |=> (l_r.word_tgl != $past(l_r.word_tgl) && l_r.word == $past(l_r.sr[POS_START-1:POS_STOP+1])))
    else $error("Good word not emitted");

  // ---------------- System domain ----------------

  // Output-side state, clocked by the system clock
  typedef struct packed {
    logic                 oe_s1;     // Output enable sync
    logic                 oe_s2;
    logic                 pdn_s1;    // Power-down sync
    logic                 pdn_s2;
    logic                 sel_s1;    // Edge select sync
    logic                 sel_s2;
    logic                 lk_s1;     // Lock level sync
    logic                 lk_s2;
    logic                 tg_s1;     // Word toggle sync
    logic                 tg_s2;
    logic                 tg_s3;     // Previous toggle, for the edge
    logic [DATA_BITS-1:0] word;      // Presented word
    logic                 vld;       // Presented word is fresh
    logic                 rclk;      // Strobe level
    logic                 unlocked;  // Unlocked flag
    logic                 word_oe_n; // Data and strobe release
    logic                 unl_oe_n;  // Flag release
    logic                 buf_rdy;   // Buffer room, registered
  } edlk_sys_t;

  edlk_sys_t            s_r;       // Registered output state
  edlk_sys_t            s_nxt;     // Next output state
  logic                 push;      // New word arrived from the link
  logic                 in_ready;  // Buffer room
  logic                 b_valid;   // Buffer has a word
  logic                 pop;       // Word moves to the pins
  logic [DATA_BITS-1:0] b_data;    // Buffer head
  logic                 flush;     // Drop buffered words

  assign push  = s_r.tg_s2 ^ s_r.tg_s3;
  assign flush = !s_r.lk_s2 || !s_r.pdn_s2;
  assign pop   = b_valid && s_r.lk_s2 && (!s_r.vld || rx_ready_i);

  // Link word is stable for a whole frame, far longer than the toggle sync takes
  edlk_buf #(
    .WIDTH (DATA_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (flush),
    .in_valid_i  (push),
    .in_ready_o  (in_ready),
    .in_data_i   (l_r.word),
    .out_valid_o (b_valid),
    .out_ready_i (s_r.vld ? rx_ready_i : 1'b1),
    .out_data_o  (b_data)
  );

  // Synchronisers, output word stage, strobe and pin enables
  always_comb begin
    s_nxt        = s_r;
    s_nxt.oe_s1  = output_enable_i;
    s_nxt.oe_s2  = s_r.oe_s1;
    s_nxt.pdn_s1 = power_down_n_i;
    s_nxt.pdn_s2 = s_r.pdn_s1;
    s_nxt.sel_s1 = strobe_rise_i;
    s_nxt.sel_s2 = s_r.sel_s1;
    s_nxt.lk_s1  = l_r.locked;
    s_nxt.lk_s2  = s_r.lk_s1;
    s_nxt.tg_s1  = l_r.word_tgl;
    s_nxt.tg_s2  = s_r.tg_s1;
    s_nxt.tg_s3  = s_r.tg_s2;
    s_nxt.buf_rdy = in_ready;
    s_nxt.unlocked = !s_r.lk_s2;
    if (pop) begin
      s_nxt.word = b_data;
      s_nxt.vld  = 1'b1;
      s_nxt.rclk = s_r.sel_s2;
    end else begin
      s_nxt.rclk = !s_r.sel_s2;
      if (rx_ready_i || !s_r.lk_s2) begin
        s_nxt.vld = 1'b0;
      end
    end
    // Pins drive only when powered, enabled and, for data, locked
    s_nxt.unl_oe_n  = !(s_r.pdn_s2 && s_r.oe_s2);
    s_nxt.word_oe_n = !(s_r.pdn_s2 && s_r.oe_s2 && s_r.lk_s2);
  end

  // Output state register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r           <= '0;
      s_r.unlocked  <= UNLOCK_RST;
      s_r.word_oe_n <= OE_N_RST;
      s_r.unl_oe_n  <= OE_N_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign word_o          = s_r.word;
  assign word_valid_o    = s_r.vld;
  assign word_oe_n_o     = s_r.word_oe_n;
  assign rec_clk_o       = s_r.rclk;
  assign rec_clk_oe_n_o  = s_r.word_oe_n;
  assign unlocked_o      = s_r.unlocked;
  assign unlocked_oe_n_o = s_r.unl_oe_n;
  assign buf_ready_o     = s_r.buf_rdy;

  AST_UNLOCK_RELEASE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    unlocked_o |-> (word_oe_n_o && rec_clk_oe_n_o)) else $error("Data driven while unlocked");
  AST_OE_RELEASE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !s_r.oe_s2 |=> (word_oe_n_o && rec_clk_oe_n_o && unlocked_oe_n_o)) else $error("Pins driven while disabled");
  AST_PDN_RELEASE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !s_r.pdn_s2 |=> (word_oe_n_o && unlocked_oe_n_o)) else $error("Pins driven in power down");
  AST_STROBE_EDGE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    pop |=> (rec_clk_o == $past(s_r.sel_s2) && word_valid_o && word_o == $past(b_data)))
    else $error("Strobe edge or word wrong on load");
  AST_LOCK_FLAG: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $fell(unlocked_o) |-> $past(s_r.lk_s2)) else $error("Unlocked cleared without lock");
  AST_ENABLE_ON_LOCK: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (s_r.pdn_s2 && s_r.oe_s2 && s_r.lk_s2) |=> !word_oe_n_o ##0 !unlocked_oe_n_o)
    else $error("Pins not driven once locked");

endmodule
